/* shared/wbt_pkg.sv */
// Constants and types shared by the write-burst device core and its store.
// Assumes one link clock for commands, data and strobes, and a separate core clock.
package wbt_pkg;

  // ==========================================================================
  // Array geometry
  localparam int WBT_BA_W = 2;
  localparam int WBT_BANKS = 4;
  localparam int WBT_ROW_W = 3;
  localparam int WBT_COL_W = 4;
  localparam int WBT_ADDR_W = 11;
  localparam int WBT_DQ_W = 16;
  localparam int WBT_LANES = 2;
  localparam int WBT_MEM_AW = WBT_BA_W + WBT_ROW_W + WBT_COL_W;
  localparam int WBT_MEM_DEPTH = 1 << WBT_MEM_AW;

  // ==========================================================================
  // Command field positions and encodings {cs_n, ras_n, cas_n, we_n}
  localparam int WBT_A10_BIT = 10;
  localparam logic [3:0] WBT_CMD_ACT = 4'h3;
  localparam logic [3:0] WBT_CMD_WRITE = 4'h4;
  localparam logic [3:0] WBT_CMD_PRE = 4'h2;

  // ==========================================================================
  // Burst and latency limits
  localparam int WBT_MAX_WL = 16;
  localparam logic [2:0] WBT_LAST_BL4 = 3'h3;
  localparam logic [2:0] WBT_LAST_BL8 = 3'h7;

  // ==========================================================================
  // Mode setting vector layout {wr, al, cl, bl8, interleave}
  localparam int WBT_CFG_W = 11;
  localparam int WBT_CFG_INTL = 0;
  localparam int WBT_CFG_BL8 = 1;
  localparam int WBT_CFG_CL_LO = 2;
  localparam int WBT_CFG_AL_LO = 5;
  localparam int WBT_CFG_WR_LO = 8;

  // Queued write command waiting out the write latency
  typedef struct packed {
    logic v;
    logic [WBT_BA_W-1:0] ba;
    logic [WBT_ROW_W-1:0] row;
    logic [WBT_COL_W-1:0] col;
    logic ap;
  } wbt_desc_t;

endpackage

/* shared/wbt_mem_if.sv */
// Carrier between the burst engine and the storage array, on the link clock.
// Assumes both ends sit in the link clock domain.
interface wbt_mem_if;
  import wbt_pkg::*;
  logic [WBT_LANES-1:0] we;
  logic [WBT_MEM_AW-1:0] waddr;
  logic [WBT_DQ_W-1:0] wdata;
  logic [WBT_MEM_AW-1:0] raddr;
  logic [WBT_DQ_W-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* core/wbt_store.sv */
// Byte-lane writable storage array with one registered read port.
// Assumes the writer and reader both run on the link clock.
module wbt_store
  import wbt_pkg::*;
(
  // Link clock and reset
  input wire logic ck,
  input wire logic rst_n,
  // Array access
  wbt_mem_if.store mem
);

  typedef struct packed {
    logic [WBT_DQ_W-1:0] rdata;
  } wbt_store_t;

  wbt_store_t q;
  wbt_store_t d;
  logic [WBT_DQ_W-1:0] cells [WBT_MEM_DEPTH];

  // ==========================================================================
  // Read path
  always_comb begin
    d = q;
    d.rdata = cells[mem.raddr];
  end

  always_ff @(posedge ck or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign mem.rdata = q.rdata;

  // ==========================================================================
  // Write path: each lane lands on its own enable
  always_ff @(posedge ck) begin
    for (int l = 0; l < WBT_LANES; l++) begin
      if (mem.we[l]) begin
        cells[mem.waddr][l*8 +: 8] <= mem.wdata[l*8 +: 8];
      end
    end
  end

endmodule

/* core/wbt_core.sv */
// Write-burst side of a double-data-rate memory device, with a core read port.
// Assumes commands, data, mask and strobes are synchronous to ck; mode inputs
// are quasi static and come from the mclk domain.
module wbt_core
  import wbt_pkg::*;
(
  // Core clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Mode settings
  input wire logic [2:0] cfg_cl,
  input wire logic [2:0] cfg_al,
  input wire logic [2:0] cfg_wr,
  input wire logic cfg_bl8,
  input wire logic cfg_interleave,
  // Link
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [WBT_BA_W-1:0] ba,
  input wire logic [WBT_ADDR_W-1:0] addr,
  input wire logic [WBT_DQ_W-1:0] dq,
  input wire logic [WBT_LANES-1:0] dm,
  input wire logic dqs_lo,
  input wire logic dqs_hi,
  // Core inspection port
  input wire logic rd_req,
  input wire logic [WBT_MEM_AW-1:0] rd_addr,
  output logic rd_valid,
  output logic [WBT_DQ_W-1:0] rd_data,
  output logic [WBT_BANKS-1:0] bank_open,
  output logic burst_busy
);

  typedef struct packed {
    logic [WBT_CFG_W-1:0] cfg_s1;
    logic [WBT_CFG_W-1:0] cfg_s2;
    wbt_desc_t [WBT_MAX_WL-1:0] dl;
    wbt_desc_t bst;
    logic [2:0] idx;
    logic [WBT_BANKS-1:0] open;
    logic [WBT_BANKS-1:0][WBT_ROW_W-1:0] row;
    logic [WBT_BANKS-1:0] ap_pend;
    logic [WBT_BANKS-1:0][2:0] ap_cnt;
    logic rq_s1;
    logic rq_s2;
    logic rq_s3;
    logic [WBT_MEM_AW-1:0] raddr;
    logic rd_p1;
    logic rd_p2;
    logic ack_tg;
    logic [WBT_DQ_W-1:0] hold;
    logic busy;
  } wbt_link_t;

  typedef struct packed {
    logic req_tg;
    logic pend;
    logic [WBT_MEM_AW-1:0] addr_hold;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic rd_valid;
    logic [WBT_DQ_W-1:0] rd_data;
    logic [WBT_BANKS-1:0] open_s1;
    logic [WBT_BANKS-1:0] open_s2;
    logic busy_s1;
    logic busy_s2;
  } wbt_mcore_t;

  wbt_link_t lq;
  wbt_link_t ld;
  wbt_mcore_t cq;
  wbt_mcore_t cd;

  wbt_mem_if mem_bus ();

  wbt_store u_store (
    .ck (ck),
    .rst_n (rst_n),
    .mem (mem_bus.store)
  );

  // ==========================================================================
  // Link domain: command decode, latency pipe, burst engine
  always_comb begin
    logic [3:0] cmd;
    logic [2:0] cl;
    logic [2:0] al;
    logic [4:0] wl;
    logic [2:0] last;
    logic [2:0] lo;
    wbt_desc_t emerge;
    wbt_desc_t cur;
    logic [2:0] idx;
    cmd = {cs_n, ras_n, cas_n, we_n};
    cl = lq.cfg_s2[WBT_CFG_CL_LO +: 3];
    al = lq.cfg_s2[WBT_CFG_AL_LO +: 3];
    wl = 5'({2'h0, al} + {2'h0, cl} - 5'h01);
    if (wl == 5'h00) begin
      wl = 5'h01;
    end else if (wl > 5'(WBT_MAX_WL)) begin
      wl = 5'(WBT_MAX_WL);
    end
    last = lq.cfg_s2[WBT_CFG_BL8] ? WBT_LAST_BL8 : WBT_LAST_BL4;
    emerge = '0;
    cur = '0;
    idx = '0;
    lo = '0;
    ld = lq;
    ld.cfg_s1 = {cfg_wr, cfg_al, cfg_cl, cfg_bl8, cfg_interleave};
    ld.cfg_s2 = lq.cfg_s1;
    mem_bus.we = '0;
    mem_bus.wdata = dq;

    // Auto precharge countdown runs per bank, so bursts to other banks overlap
    for (int b = 0; b < WBT_BANKS; b++) begin
      if (lq.ap_pend[b]) begin
        if (lq.ap_cnt[b] == 3'h0) begin
          ld.ap_pend[b] = 1'b0;
          ld.open[b] = 1'b0;
        end else begin
          ld.ap_cnt[b] = lq.ap_cnt[b] - 3'h1;
        end
      end
    end

    // Latency pipe: a write leaves stage wl-1 on its first data edge
    emerge = lq.dl[wl-5'h01];
    for (int i = WBT_MAX_WL - 1; i > 0; i--) begin
      ld.dl[i] = lq.dl[i-1];
    end
    ld.dl[0] = '0;
    if (cmd == WBT_CMD_WRITE) begin
      ld.dl[0].v = 1'b1;
      ld.dl[0].ba = ba;
      ld.dl[0].row = lq.row[ba];
      ld.dl[0].col = addr[WBT_COL_W-1:0];
      ld.dl[0].ap = addr[WBT_A10_BIT];
    end

    // A newly due write takes over: concatenation or the two-clock interrupt
    cur = lq.bst;
    idx = lq.idx;
    if (emerge.v) begin
      cur = emerge;
      idx = 3'h0;
    end
    ld.bst = cur;
    ld.idx = idx;
    lo = lq.cfg_s2[WBT_CFG_INTL] ? (cur.col[2:0] ^ idx) : (cur.col[2:0] + idx);
    if (!lq.cfg_s2[WBT_CFG_BL8]) begin
      lo[2] = cur.col[2];
    end
    mem_bus.waddr = {cur.ba, cur.row, cur.col[WBT_COL_W-1:3], lo};
    if (cur.v) begin
      mem_bus.we[0] = dqs_lo & ~dm[0];
      mem_bus.we[1] = dqs_hi & ~dm[1];
      ld.idx = idx + 3'h1;
      if (idx == last) begin
        ld.bst.v = 1'b0;
        // Recovery counted from burst end whatever the mask did
        if (cur.ap) begin
          ld.ap_pend[cur.ba] = 1'b1;
          ld.ap_cnt[cur.ba] = lq.cfg_s2[WBT_CFG_WR_LO +: 3];
        end
      end
    end

    // Row commands
    if (cmd == WBT_CMD_ACT) begin
      ld.open[ba] = 1'b1;
      ld.row[ba] = addr[WBT_ROW_W-1:0];
    end else if (cmd == WBT_CMD_PRE) begin
      if (addr[WBT_A10_BIT]) begin
        ld.open = '0;
        ld.ap_pend = '0;
      end else begin
        ld.open[ba] = 1'b0;
        ld.ap_pend[ba] = 1'b0;
      end
    end

    ld.busy = ld.bst.v | (|ld.ap_pend);
    for (int i = 0; i < WBT_MAX_WL; i++) begin
      ld.busy = ld.busy | ld.dl[i].v;
    end

    // Inspection read: request toggle in, data hold and ack toggle out
    ld.rq_s1 = cq.req_tg;
    ld.rq_s2 = lq.rq_s1;
    ld.rq_s3 = lq.rq_s2;
    ld.rd_p1 = 1'b0;
    ld.rd_p2 = lq.rd_p1;
    if (lq.rq_s2 != lq.rq_s3) begin
      // Address is held steady by the core side until the ack returns
      ld.raddr = cq.addr_hold;
      ld.rd_p1 = 1'b1;
    end
    if (lq.rd_p2) begin
      ld.hold = mem_bus.rdata;
      ld.ack_tg = ~lq.ack_tg;
    end
    mem_bus.raddr = lq.raddr;
  end

  always_ff @(posedge ck or negedge rst_n) begin
    if (!rst_n) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // ==========================================================================
  // Core domain: request handshake and status synchronisers
  always_comb begin
    cd = cq;
    cd.rd_valid = 1'b0;
    cd.ack_s1 = lq.ack_tg;
    cd.ack_s2 = cq.ack_s1;
    cd.ack_s3 = cq.ack_s2;
    cd.open_s1 = lq.open;
    cd.open_s2 = cq.open_s1;
    cd.busy_s1 = lq.busy;
    cd.busy_s2 = cq.busy_s1;
    if (rd_req && !cq.pend) begin
      cd.pend = 1'b1;
      cd.addr_hold = rd_addr;
      cd.req_tg = ~cq.req_tg;
    end
    if (cq.pend && (cq.ack_s2 != cq.ack_s3)) begin
      cd.pend = 1'b0;
      cd.rd_valid = 1'b1;
      cd.rd_data = lq.hold;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cq <= '0;
    end else begin
      cq <= cd;
    end
  end

  assign rd_valid = cq.rd_valid;
  assign rd_data = cq.rd_data;
  assign bank_open = cq.open_s2;
  assign burst_busy = cq.busy_s2;

endmodule

/* tb/wbt_core_checker.sv */
// Port checks of the write-burst core.
// Assumes a bind onto wbt_core; link checks run on ck.
module wbt_checker
  import wbt_pkg::*;
(
  // Clocks and reset
  input wire logic mclk,
  input wire logic ck,
  input wire logic rst_n,
  // Link
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [WBT_BA_W-1:0] ba,
  input wire logic [WBT_ADDR_W-1:0] addr,
  // Core side
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic [WBT_BANKS-1:0] bank_open,
  input wire logic burst_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // Decode
  logic [3:0] c;
  logic a10;
  assign c = {cs_n, ras_n, cas_n, we_n};
  assign a10 = addr[WBT_A10_BIT];
  property p_act;
    @(posedge ck) disable iff (!rst_n) c == WBT_CMD_ACT && ba == 2'h0 |-> ##[1:12] bank_open[0];
  endproperty
  a_act: assert property (p_act) else $error("bank not opened");
  property p_pre;
    @(posedge ck) disable iff (!rst_n) c == WBT_CMD_PRE && ba == 2'h0 |-> ##[1:12] !bank_open[0];
  endproperty
  a_pre: assert property (p_pre) else $error("bank not closed");
  property p_oth;
    @(posedge ck) disable iff (!rst_n) c == WBT_CMD_PRE && !a10 && ba != 2'h0 && bank_open[0]
      |-> ##1 bank_open[0] [*6];
  endproperty
  a_oth: assert property (p_oth) else $error("other bank closed");
  property p_noap;
    @(posedge ck) disable iff (!rst_n) c == WBT_CMD_WRITE && !a10 && ba == 2'h0 && bank_open[0]
      |-> ##1 bank_open[0] [*8];
  endproperty
  a_noap: assert property (p_noap) else $error("row closed without A10");
  property p_ap;
    @(posedge ck) disable iff (!rst_n) c == WBT_CMD_WRITE && a10 && ba == 2'h1 && bank_open[1]
      |-> ##1 bank_open[1] [*4] ##[1:40] !bank_open[1];
  endproperty
  a_ap: assert property (p_ap) else $error("auto precharge wrong");
  property p_busy;
    @(posedge ck) disable iff (!rst_n) c == WBT_CMD_WRITE |-> ##[1:10] burst_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("write not taken");
  property p_rvp;
    @(posedge mclk) disable iff (!rst_n) rd_valid |=> !rd_valid;
  endproperty
  a_rvp: assert property (p_rvp) else $error("read valid too long");
  property p_rda;
    @(posedge mclk) disable iff (!rst_n) $rose(rd_req) |-> ##[1:20] rd_valid;
  endproperty
  a_rda: assert property (p_rda) else $error("read not answered");
  c_apw: cover property (@(posedge ck) c == WBT_CMD_WRITE && a10);
  c_rd: cover property (@(posedge mclk) rd_valid);
  c_done: cover property (@(posedge mclk) $fell(burst_busy));
endmodule

bind wbt_core wbt_checker u_chk (.mclk, .ck, .rst_n, .cs_n, .ras_n, .cas_n, .we_n, .ba,
  .addr, .rd_req, .rd_valid, .bank_open, .burst_busy);

/* tb/wbt_ctl_model.sv */
// Controller stand-in driving commands, data, masks and lane strobes.
// Assumes the bench passes the write latency with each write and calls its tasks.
module wbt_ctl_model
  import wbt_pkg::*;
(
  // Link clock
  input wire logic ck,
  // Link
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [10:0] addr,
  output logic [15:0] dq,
  output logic [1:0] dm,
  output logic dqs_lo,
  output logic dqs_hi
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [19:0] q[$];
  logic [19:0] e;
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    {ba, addr, dq, dm, dqs_lo, dqs_hi} = '0;
  end
  // ====
  // One slot per link clock, changed mid-cycle so edges see it settled
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [10:0] a);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    e = (q.size() > 0) ? q.pop_front() : 20'h0;
    {dqs_hi, dqs_lo, dm} = e[19:16];
    // Released bus shows the inverse of its last value
    dq = (e[19:18] != 2'h0) ? e[15:0] : ~dq;
  endtask
  // Elements start lat slots on, in a row; a newer write cuts the rest
  task automatic wr(input logic [1:0] b, input logic [10:0] a, input int n,
    input logic [15:0] d, input logic [3:0] sm, input int lat);
    while (q.size() < lat) q.push_back(20'h0);
    while (q.size() > lat) q.pop_back();
    for (int i = 0; i < n; i++) q.push_back({sm, d + 16'(i)});
    cmd(WBT_CMD_WRITE, b, a);
  endtask
endmodule

/* tb/tb_top.sv */
// Bench: clocks, reset, controller model, core and read-back checks.
// Assumes CL 3; AL 0 except one case, so write latency is mostly two link clocks.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import wbt_pkg::*;
  logic mclk = 1'b0;
  logic ck = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] cfg_wr = 3'h3; // Recovery of 3 clocks, rounded up
  logic [2:0] cfg_al = 3'h0;
  logic cfg_bl8 = 1'b0;
  logic cfg_intl = 1'b0;
  logic rd_req = 1'b0;
  logic [8:0] rd_addr = 9'h0;
  logic rd_valid, burst_busy, cs_n, ras_n, cas_n, we_n, dqs_lo, dqs_hi;
  logic [15:0] rd_data, dq;
  logic [3:0] bank_open;
  logic [1:0] ba, dm;
  logic [10:0] addr;
  logic [15:0] em [0:511];
  logic [2:0] rw [0:3];
  logic [7:0] rows [4] = '{8'h14, 8'h69, 8'hAE, 8'hDB};
  int fail_count = 0;
  int comparisons = 0;
  always #5 mclk = ~mclk;
  initial begin
    #1.7;
    forever #3 ck = ~ck;
  end
  wbt_core u_dut (.mclk, .rst_n, .cfg_cl(3'h3), .cfg_al, .cfg_wr, .cfg_bl8,
    .cfg_interleave(cfg_intl), .ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq, .dm,
    .dqs_lo, .dqs_hi, .rd_req, .rd_addr, .rd_valid, .rd_data, .bank_open, .burst_busy);
  wbt_ctl_model u_ctl (.ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq, .dm, .dqs_lo,
    .dqs_hi);
  // ====
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) u_ctl.cmd(4'h7, 2'h0, 11'h0);
  endtask
  // A lone command stands one edge only, then the lines go idle
  task automatic wbo(input logic [3:0] e);
    idle(1);
    for (int k = 0; k < 20 && bank_open !== e; k++) @(negedge mclk);
    chk({12'h0, bank_open}, {12'h0, e});
  endtask
  task automatic rd(input logic [8:0] a);
    @(negedge mclk);
    rd_req = 1'b1;
    rd_addr = a;
    @(negedge mclk);
    rd_req = 1'b0;
    for (int k = 0; k < 25 && rd_valid !== 1'b1; k++) @(negedge mclk);
    chk({15'h0, rd_valid}, 16'h1);
    if (rd_valid !== 1'b1) complete_run();
    chk(rd_data, em[a]);
  endtask
  // Expected lanes land where strobed and unmasked
  task automatic wr(input logic [1:0] b, input logic [3:0] c, input logic ap, input int keep,
    input logic [15:0] d, input logic [3:0] sm);
    logic [3:0] cc;
    for (int i = 0; i < keep; i++) begin
      cc = c;
      cc[2:0] = cfg_intl ? c[2:0] ^ 3'(i) : c[2:0] + 3'(i);
      if (!cfg_bl8) cc[2] = c[2];
      for (int l = 0; l < 2; l++) begin
        if (sm[2+l] && !sm[l]) em[{b, rw[b], cc}][8*l+:8] = 8'((d + 16'(i)) >> (8 * l));
      end
    end
    u_ctl.wr(b, {ap, 6'h0, c}, cfg_bl8 ? 8 : 4, d, sm, 2 + int'(cfg_al));
  endtask
  // ====
  // Sequence
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    idle(4);
    for (int b = 0; b < 4; b++) begin
      rw[b] = 3'(b + 2);
      u_ctl.cmd(WBT_CMD_ACT, 2'(b), 11'(b + 2));
    end
    wbo(4'hF);
    // Rows: bank, start column, length 8, interleave
    foreach (rows[r]) begin
      @(negedge mclk);
      {cfg_bl8, cfg_intl} = rows[r][1:0];
      idle(4);
      wr(rows[r][7:6], rows[r][5:2], 1'b0, cfg_bl8 ? 8 : 4, 16'h1111 * 16'(r + 1), 4'hC);
      idle(12); // Recovery before any later access
    end
    @(negedge mclk);
    {cfg_bl8, cfg_intl} = 2'b00;
    idle(4);
    wr(2'h0, 4'h5, 1'b0, 4, 16'hA0A0, 4'hE);
    idle(4);
    wr(2'h0, 4'h5, 1'b0, 4, 16'h5B5B, 4'h8);
    idle(8);
    @(negedge mclk);
    cfg_al = 3'h1;
    idle(4);
    wr(2'h3, 4'h9, 1'b0, 4, 16'hC000, 4'hC); // Latency three with AL 1
    idle(12);
    @(negedge mclk);
    cfg_al = 3'h0;
    cfg_bl8 = 1'b1;
    idle(4);
    // Cut after two elements, other bank, nothing but idle meanwhile
    wr(2'h1, 4'h0, 1'b0, 2, 16'h7000, 4'hC);
    idle(1);
    wr(2'h2, 4'h8, 1'b0, 8, 16'h8000, 4'hC);
    idle(16);
    @(negedge mclk);
    cfg_bl8 = 1'b0;
    idle(4);
    wr(2'h1, 4'h3, 1'b1, 4, 16'h9000, 4'hC);
    idle(6);
    chk({15'h0, burst_busy}, 16'h1);
    idle(10);
    wbo(4'hD);
    u_ctl.cmd(WBT_CMD_ACT, 2'h1, 11'h3);
    wbo(4'hF);
    for (int a = 0; a < 512; a++) if (!$isunknown(em[a])) rd(9'(a));
    u_ctl.cmd(WBT_CMD_PRE, 2'h3, 11'h0);
    wbo(4'h7);
    u_ctl.cmd(WBT_CMD_PRE, 2'h0, 11'h400);
    wbo(4'h0);
    u_ctl.cmd(WBT_CMD_ACT, 2'h2, 11'h1);
    wbo(4'h4);
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    chk({11'h0, bank_open, burst_busy}, 16'h0);
    rst_n = 1'b1;
    @(negedge mclk);
    chk({11'h0, bank_open, burst_busy}, 16'h0);
    chk({15'h0, rd_valid}, 16'h0);
    complete_run();
  end
endmodule
